// ===== hw/edbp_pin_if.sv
`timescale 1ns/1ps
// ==========================================================================
// Next-cycle pin values carried from the sequencer to the pin stage.
interface edbp_pin_if;
  logic        bank_d;
  logic [12:0] addr_d;
  logic        ctrl_oe_d;
  logic        rd_n_d;
  logic        wr_n_d;
  logic [15:0] wdata_d;
  logic        data_oe_d;
  logic        grant_n_d;
  logic        owner_n_d;

  modport ctrl  (output bank_d, addr_d, ctrl_oe_d, rd_n_d, wr_n_d, wdata_d,
                 data_oe_d, grant_n_d, owner_n_d);
  modport stage (input  bank_d, addr_d, ctrl_oe_d, rd_n_d, wr_n_d, wdata_d,
                 data_oe_d, grant_n_d, owner_n_d);
endinterface : edbp_pin_if

// ===== hw/edbp_pin_stage.sv
`timescale 1ns/1ps
// ==========================================================================
// Output register stage: every pin value and enable leaves from a flop.
module edbp_pin_stage (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  edbp_pin_if.stage        pins,
  output logic             bank_sel_out,
  output logic             bank_sel_oe,
  output logic [12:0]      ext_addr_out,
  output logic             ext_addr_oe,
  output logic             mem_read_strobe_n,
  output logic             mem_read_strobe_oe,
  output logic             mem_write_strobe_n,
  output logic             mem_write_strobe_oe,
  output logic [15:0]      ext_data_out,
  output logic             ext_data_oe,
  output logic             bus_hold_grant_n,
  output logic             bus_owner_strobe_n
);

  // Pins take their next values on every rising edge; reset gives the quiet bus.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bank_sel_out        <= edbp_pkg::BANK_X;
      bank_sel_oe         <= edbp_pkg::OE_RST;
      ext_addr_out        <= edbp_pkg::ADDR_RST;
      ext_addr_oe         <= edbp_pkg::OE_RST;
      mem_read_strobe_n   <= edbp_pkg::STROBE_IDLE;
      mem_read_strobe_oe  <= edbp_pkg::OE_RST;
      mem_write_strobe_n  <= edbp_pkg::STROBE_IDLE;
      mem_write_strobe_oe <= edbp_pkg::OE_RST;
      ext_data_out        <= 16'h0000;
      ext_data_oe         <= 1'b0;
      bus_hold_grant_n    <= edbp_pkg::STROBE_IDLE;
      bus_owner_strobe_n  <= edbp_pkg::STROBE_IDLE;
    end else begin
      bank_sel_out        <= pins.bank_d;
      bank_sel_oe         <= pins.ctrl_oe_d;
      ext_addr_out        <= pins.addr_d;
      ext_addr_oe         <= pins.ctrl_oe_d;
      mem_read_strobe_n   <= pins.rd_n_d;
      mem_read_strobe_oe  <= pins.ctrl_oe_d;
      mem_write_strobe_n  <= pins.wr_n_d;
      mem_write_strobe_oe <= pins.ctrl_oe_d;
      ext_data_out        <= pins.wdata_d;
      ext_data_oe         <= pins.data_oe_d;
      bus_hold_grant_n    <= pins.grant_n_d;
      bus_owner_strobe_n  <= pins.owner_n_d;
    end
  end

endmodule // edbp_pin_stage

// ===== hw/edbp_pkg.sv
// ==========================================================================
// Shared constants of the external data memory bus port.
package edbp_pkg;

  localparam int          ADDR_W        = 13;         // External address width.
  localparam int          DATA_W        = 16;         // External data width.
  localparam int          ACCESS_CYCLES = 2;          // Clock cycles per access.
  localparam logic [12:0] ADDR_RST      = 13'h0000;   // Address shown after reset.
  localparam logic        BANK_X        = 1'b0;       // Bank select code for X.
  localparam logic        BANK_Y        = 1'b1;       // Bank select code for Y.
  localparam logic        STROBE_IDLE   = 1'b1;       // Inactive level of a low strobe.
  localparam logic        OE_RST        = 1'b1;       // Control pins driven after reset.

endpackage : edbp_pkg

// ===== hw/edbp_port.sv
`timescale 1ns/1ps
// ==========================================================================
// Overview of operation
// RQ1 - Bank select pin is 0 for X bank accesses and 1 for Y bank.
// RQ2 - Between accesses the address pins keep showing the last accessed address.
// RQ3 - After reset the address pins stay 0x000 until the first access.
// RQ4 - An outside master asks for the bus by pulling hold request low.
// RQ5 - Bus owner strobe is low while this port itself uses the bus.
// RQ6 - Hold grant goes low when the bus is handed to the outside master.
// RQ7 - While granted, bank select, address and both strobes float.
// RQ8 - Data pins float unless writing, and always while the bus is granted.
// RQ9 - Read strobe low on reads, write strobe low on writes, data driven on writes.
// RQ10 - An access in flight completes first; ownership returns once hold request rises.
module edbp_port #(
  parameter int ACCESS_CYCLES = edbp_pkg::ACCESS_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_bank,
  input  wire logic [12:0] req_addr,
  input  wire logic [15:0] req_wdata,
  output logic             req_ready,
  output logic             done_pulse,
  output logic [15:0]      rd_data,
  output logic             bank_sel_out,
  output logic             bank_sel_oe,
  output logic [12:0]      ext_addr_out,
  output logic             ext_addr_oe,
  output logic             mem_read_strobe_n,
  output logic             mem_read_strobe_oe,
  output logic             mem_write_strobe_n,
  output logic             mem_write_strobe_oe,
  input  wire logic [15:0] ext_data_in,
  output logic [15:0]      ext_data_out,
  output logic             ext_data_oe,
  input  wire logic        bus_hold_request_n,
  output logic             bus_hold_grant_n,
  output logic             bus_owner_strobe_n
);

  // ========================================================================
  // State and registers.
  typedef enum logic [1:0] {EDBP_IDLE, EDBP_ACCESS, EDBP_RELEASED} edbp_state_e;
  typedef logic [7:0] edbp_cnt_t;

  localparam edbp_cnt_t CNT_LAST = edbp_cnt_t'(ACCESS_CYCLES - 1);

  edbp_state_e state_q, state_d;
  edbp_cnt_t   cnt_q, cnt_d;
  logic [12:0] addr_q, addr_d;
  logic        bank_q, bank_d;
  logic        write_q, write_d;
  logic [15:0] wdata_q, wdata_d;
  logic        ready_q, ready_d;
  logic        done_q, done_d;
  logic [15:0] rdata_q, rdata_d;

  edbp_pin_if pins ();

  // ========================================================================
  // Decoding of the current cycle.
  wire hold_req  = ~bus_hold_request_n;                               // RQ4
  wire take_req  = (state_q == EDBP_IDLE) && ~hold_req && req_valid;
  wire last_beat = (state_q == EDBP_ACCESS) && (cnt_q == 8'h00);
  wire in_access = (state_d == EDBP_ACCESS);

  // Next state: hold wins over a new request, but never cuts an access short.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      EDBP_IDLE: begin
        if (hold_req) begin
          state_d = EDBP_RELEASED;                                    // RQ6
        end else if (req_valid) begin
          state_d = EDBP_ACCESS;
        end
      end
      EDBP_ACCESS: begin
        if (last_beat) begin
          state_d = hold_req ? EDBP_RELEASED : EDBP_IDLE;             // RQ10
        end
      end
      EDBP_RELEASED: begin
        if (!hold_req) begin
          state_d = EDBP_IDLE;                                        // RQ10
        end
      end
    endcase
  end

  // Access registers: address and bank hold their last value between accesses.
  assign cnt_d   = take_req ? CNT_LAST : (state_q == EDBP_ACCESS ? cnt_q - 8'h01 : cnt_q);
  assign addr_d  = take_req ? req_addr  : addr_q;                     // RQ2
  assign bank_d  = take_req ? req_bank  : bank_q;                     // RQ1
  assign write_d = take_req ? req_write : write_q;
  assign wdata_d = take_req ? req_wdata : wdata_q;
  assign ready_d = (state_d == EDBP_IDLE) && ~hold_req;
  assign done_d  = last_beat;
  assign rdata_d = (last_beat && !write_q) ? ext_data_in : rdata_q;

  // Pin values one cycle ahead, so the pins line up with state_q.
  assign pins.bank_d    = bank_d;                                     // RQ1
  assign pins.addr_d    = addr_d;                                     // RQ2
  assign pins.ctrl_oe_d = (state_d != EDBP_RELEASED);                 // RQ7
  assign pins.rd_n_d    = ~(in_access && !write_d);                   // RQ9
  assign pins.wr_n_d    = ~(in_access && write_d);                    // RQ9
  assign pins.wdata_d   = wdata_d;
  assign pins.data_oe_d = in_access && write_d;                       // RQ8
  assign pins.grant_n_d = ~(state_d == EDBP_RELEASED);                // RQ6
  assign pins.owner_n_d = ~in_access;                                 // RQ5

  // Sequencer registers; the address resets to zero for the first access.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= EDBP_IDLE;
      cnt_q   <= 8'h00;
      addr_q  <= edbp_pkg::ADDR_RST;                                  // RQ3
      bank_q  <= edbp_pkg::BANK_X;
      write_q <= 1'b0;
      wdata_q <= 16'h0000;
      ready_q <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      addr_q  <= addr_d;
      bank_q  <= bank_d;
      write_q <= write_d;
      wdata_q <= wdata_d;
      ready_q <= ready_d;
      done_q  <= done_d;
      rdata_q <= rdata_d;
    end
  end

  assign req_ready  = ready_q;
  assign done_pulse = done_q;
  assign rd_data    = rdata_q;

  // ========================================================================
  // Pin output stage.
  edbp_pin_stage u_pin_stage (
    .ref_clk             (ref_clk),
    .rst                 (rst),
    .pins                (pins.stage),
    .bank_sel_out        (bank_sel_out),
    .bank_sel_oe         (bank_sel_oe),
    .ext_addr_out        (ext_addr_out),
    .ext_addr_oe         (ext_addr_oe),
    .mem_read_strobe_n   (mem_read_strobe_n),
    .mem_read_strobe_oe  (mem_read_strobe_oe),
    .mem_write_strobe_n  (mem_write_strobe_n),
    .mem_write_strobe_oe (mem_write_strobe_oe),
    .ext_data_out        (ext_data_out),
    .ext_data_oe         (ext_data_oe),
    .bus_hold_grant_n    (bus_hold_grant_n),
    .bus_owner_strobe_n  (bus_owner_strobe_n)
  );

  // ========================================================================
  // Assertions and covers.
  logic accessed_q;

  // Remembers whether any access has happened since reset.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      accessed_q <= 1'b0;
    end else if (state_q == EDBP_ACCESS) begin
      accessed_q <= 1'b1;
    end
  end

  a_bank_sel_match: assert property (@(posedge ref_clk) disable iff (rst) // RQ1
    $rose(state_q == EDBP_ACCESS) |-> bank_sel_out == $past(req_bank) && bank_sel_oe)
    else $error("bank select differs from the requested bank");

  a_addr_held_idle: assert property (@(posedge ref_clk) disable iff (rst) // RQ2
    (state_q == EDBP_IDLE) && $past(state_q == EDBP_IDLE) |-> $stable(ext_addr_out))
    else $error("address changed while no access was running");

  a_addr_zero_reset: assert property (@(posedge ref_clk) disable iff (rst) // RQ3
    !accessed_q && (state_q != EDBP_ACCESS) |-> ext_addr_out == 13'h0000)
    else $error("address not zero before the first access");

  a_owner_during_access: assert property (@(posedge ref_clk) disable iff (rst) // RQ5
    take_req |=> !bus_owner_strobe_n [*2])
    else $error("bus owner strobe not low during the access");

  a_grant_on_idle_hold: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
    (state_q == EDBP_IDLE) && !bus_hold_request_n |=> !bus_hold_grant_n)
    else $error("hold grant not given one cycle after an idle hold request");

  a_float_when_granted: assert property (@(posedge ref_clk) disable iff (rst) // RQ7
    !bus_hold_grant_n |-> !bank_sel_oe && !ext_addr_oe && !mem_read_strobe_oe
                          && !mem_write_strobe_oe && bus_owner_strobe_n)
    else $error("control pins driven while the bus is granted");

  a_data_write_only: assert property (@(posedge ref_clk) disable iff (rst) // RQ8
    ext_data_oe |-> !mem_write_strobe_n && bus_hold_grant_n)
    else $error("data pins driven outside a write");

  a_read_strobe: assert property (@(posedge ref_clk) disable iff (rst) // RQ9
    take_req && !req_write |=> !mem_read_strobe_n && mem_write_strobe_n && !ext_data_oe)
    else $error("read access has wrong strobes");

  a_finish_then_grant: assert property (@(posedge ref_clk) disable iff (rst) // RQ10
    $fell(bus_hold_grant_n) |-> $past(bus_owner_strobe_n) || $past(done_d))
    else $error("bus granted in the middle of an access");

  a_resume_after_hold: assert property (@(posedge ref_clk) disable iff (rst) // RQ10
    !bus_hold_grant_n && !bus_hold_request_n |=> !bus_hold_grant_n)
    else $error("bus taken back while hold request is still low");

  c_write_access: cover property (@(posedge ref_clk) disable iff (rst)
    take_req && req_write ##2 done_pulse);
  c_read_access: cover property (@(posedge ref_clk) disable iff (rst)
    take_req && !req_write ##2 done_pulse);
  c_hold_mid_access: cover property (@(posedge ref_clk) disable iff (rst)
    (state_q == EDBP_ACCESS) && !bus_hold_request_n ##[1:4] !bus_hold_grant_n);

endmodule // edbp_port

// ===== test/edbp_mem_model.sv
`timescale 1ns/1ps
// ==========================================================================
// External data memory on the far side of the port.
module edbp_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        bank,
  input  wire logic [12:0] addr,
  input  wire logic        ctrl_oe,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [15:0] dout,
  input  wire logic        doe,
  output logic [15:0]      din
);
  logic [15:0] mem [0:31];
  logic [15:0] last_q = 16'h0000;
  logic        mem_drive;
  logic [4:0]  idx;
  // Banks are kept apart so that a wrong bank select reads the wrong word.
  assign idx = {bank, addr[3:0]};
  assign mem_drive = ctrl_oe && !rd_n;
  // A floating wire shows the inverse of its last level, never a stale copy.
  assign din = doe ? dout : (mem_drive ? mem[idx] : ~last_q);
  // Writes land on the clock edge while the enabled write strobe is low.
  always @(posedge ref_clk) begin
    last_q <= din;
    if (ctrl_oe && !wr_n && doe) begin
      mem[idx] <= dout;
    end
  end
endmodule // edbp_mem_model

// ===== test/test_ext_data_memory_bus_port.sv
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench: the core side, the memory and an alternate master.
module test_ext_data_memory_bus_port;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic        req_bank = 1'b0;
  logic [12:0] req_addr = 13'h0000;
  logic [15:0] req_wdata = 16'h0000;
  logic        hold_n = 1'b1;
  logic        req_ready, done_pulse, bank_out, bank_oe, addr_oe, rd_n, rd_oe;
  logic        wr_n, wr_oe, data_oe, grant_n, owner_n;
  logic [15:0] rd_data, data_out, data_in;
  logic [12:0] addr_out;
  int          errors = 0;
  int          n_compared = 0;

  // The clock runs at 10 MHz.
  always #50 ref_clk = ~ref_clk;

  edbp_port edbp_port_i (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_bank(req_bank), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .done_pulse(done_pulse),
    .rd_data(rd_data), .bank_sel_out(bank_out), .bank_sel_oe(bank_oe),
    .ext_addr_out(addr_out), .ext_addr_oe(addr_oe), .mem_read_strobe_n(rd_n),
    .mem_read_strobe_oe(rd_oe), .mem_write_strobe_n(wr_n), .mem_write_strobe_oe(wr_oe),
    .ext_data_in(data_in), .ext_data_out(data_out), .ext_data_oe(data_oe),
    .bus_hold_request_n(hold_n), .bus_hold_grant_n(grant_n), .bus_owner_strobe_n(owner_n));

  edbp_mem_model edbp_mem_model_i (.ref_clk(ref_clk), .bank(bank_out), .addr(addr_out),
    .ctrl_oe(rd_oe && wr_oe), .rd_n(rd_n), .wr_n(wr_n), .dout(data_out),
    .doe(data_oe), .din(data_in));

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // A wait that runs out of its bound ends the run as a failure.
  task automatic bound(input logic ok, input string what);
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch %s expected 1 seen 0", what);
      finish_test;
    end
  endtask

  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask

  // One access; with hold set the alternate master asks for the bus mid-access.
  task automatic access(input logic wr, input logic bk, input logic [12:0] a,
                        input logic [15:0] wd, input logic hold);
    int k;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_bank <= bk;
    req_addr <= a;
    req_wdata <= wd;
    // The hold request, if any, arrives on the edge that takes the request.
    @(posedge ref_clk);
    hold_n <= !hold;
    #1;
    for (k = 0; k < 8 && owner_n !== 1'b0; k++) tick;
    bound(owner_n === 1'b0, "owner strobe");
    chk("bank", {15'h0000, bk}, {15'h0000, bank_out});
    chk("addr", {3'h0, a}, {3'h0, addr_out});
    chk("rd_n", {15'h0000, wr}, {15'h0000, rd_n});
    chk("wr_n", {15'h0000, !wr}, {15'h0000, wr_n});
    chk("data_oe", {15'h0000, wr}, {15'h0000, data_oe});
    if (wr) chk("data_out", wd, data_out);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    chk("grant_n busy", 16'h0001, {15'h0000, grant_n});
    for (k = 0; k < 8 && done_pulse !== 1'b1; k++) tick;
    bound(done_pulse === 1'b1, "done pulse");
    chk("owner_n end", 16'h0001, {15'h0000, owner_n});
    chk("grant_n end", {15'h0000, !hold}, {15'h0000, grant_n});
  endtask

  task automatic t_reset;
    chk("addr reset", 16'h0000, {3'h0, addr_out});
    chk("data_oe reset", 16'h0000, {15'h0000, data_oe});
    repeat (5) tick;
    chk("addr idle", 16'h0000, {3'h0, addr_out});
    chk("req_ready idle", 16'h0001, {15'h0000, req_ready});
    chk("pin enables idle", 16'h000f, {12'h000, bank_oe, addr_oe, rd_oe, wr_oe});
    chk("owner_n idle", 16'h0001, {15'h0000, owner_n});
    $display("test reset done");
  endtask

  task automatic t_write_read;
    access(1'b1, edbp_pkg::BANK_X, 13'h01a5, 16'hbeef, 1'b0);
    access(1'b1, edbp_pkg::BANK_Y, 13'h01a5, 16'h1234, 1'b0);
    repeat (3) tick;
    chk("addr held", 16'h01a5, {3'h0, addr_out});
    chk("data_oe idle", 16'h0000, {15'h0000, data_oe});
    access(1'b0, edbp_pkg::BANK_X, 13'h01a5, 16'h0000, 1'b0);
    chk("rd_data x", 16'hbeef, rd_data);
    access(1'b0, edbp_pkg::BANK_Y, 13'h01a5, 16'h0000, 1'b0);
    chk("rd_data y", 16'h1234, rd_data);
    $display("test write read done");
  endtask

  // Checks the released pins, keeps a core request waiting, then returns the bus.
  task automatic released_then_return;
    int k;
    chk("grant_n", 16'h0000, {15'h0000, grant_n});
    chk("pin enables", 16'h0000, {12'h000, bank_oe, addr_oe, rd_oe, wr_oe});
    chk("data_oe held", 16'h0000, {15'h0000, data_oe});
    chk("req_ready held", 16'h0000, {15'h0000, req_ready});
    // The core request stays up until the port takes it after the bus returns.
    @(posedge ref_clk);
    req_valid <= 1'b1;
    repeat (4) tick;
    chk("owner_n held", 16'h0001, {15'h0000, owner_n});
    @(posedge ref_clk);
    hold_n <= 1'b1;
    for (k = 0; k < 8 && grant_n !== 1'b1; k++) tick;
    bound(grant_n === 1'b1, "grant release");
    tick;
    chk("pin enables back", 16'h000f, {12'h000, bank_oe, addr_oe, rd_oe, wr_oe});
    chk("owner_n resumed", 16'h0000, {15'h0000, owner_n});
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    for (k = 0; k < 8 && done_pulse !== 1'b1; k++) tick;
    bound(done_pulse === 1'b1, "resumed done");
    chk("owner_n after", 16'h0001, {15'h0000, owner_n});
  endtask

  task automatic t_hold_idle;
    int k;
    @(posedge ref_clk);
    hold_n <= 1'b0;
    for (k = 0; k < 8 && grant_n !== 1'b0; k++) tick;
    bound(grant_n === 1'b0, "grant");
    released_then_return;
    $display("test hold idle done");
  endtask

  task automatic t_hold_busy;
    access(1'b1, edbp_pkg::BANK_Y, 13'h1ffe, 16'ha5c3, 1'b1);
    tick;
    released_then_return;
    $display("test hold busy done");
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    tick;
    t_reset;
    t_write_read;
    t_hold_idle;
    t_hold_busy;
    finish_test;
  end
endmodule // test_ext_data_memory_bus_port
